//--- cab_alu.sv
// Register access over AXI4-Lite and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module cab_alu (
  // Clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // Decoded instruction from the sequencer
  input wire logic OP_VALID,
  input wire logic [3:0] OP_CODE,
  input wire logic [6:0] OP_FILE,
  input wire logic [2:0] OP_BIT,
  input wire logic [7:0] OP_LIT,
  input wire logic OP_DEST,
  // Port pins
  input wire logic [cab_pkg::CAB_PORT_W-1:0] PIN_IN,
  output logic [cab_pkg::CAB_PORT_W-1:0] PORT_OUT,
  // Core state
  output logic [7:0] W_OUT,
  output logic [2:0] FLAGS_OUT,
  output logic SKIP_OUT,
  // AXI4-Lite slave
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  typedef struct packed {
    cab_pkg::cab_state_t st;
    logic [7:0] work;
    logic [2:0] flags;
    logic [127:0][7:0] mem;
    logic [cab_pkg::CAB_PORT_W-1:0] port_latch;
    logic [cab_pkg::CAB_PORT_W-1:0] pin_meta;
    logic [cab_pkg::CAB_PORT_W-1:0] pin_sync;
    logic [7:0] timer;
    logic [7:0] presc;
    logic presc_timer;
    logic skip;
    logic awready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } cab_regs_t;

  cab_regs_t r_reg;
  cab_regs_t r_next;
  cab_pkg::cab_op_t op;
  logic exec;
  logic [7:0] fval;
  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] res;
  logic to_file;
  logic bit_val;
  logic skip_take;

  // ==========================================================================
  // Operand fetch and arithmetic
  assign op = cab_pkg::cab_op_t'(OP_CODE);
  assign exec = OP_VALID && (r_reg.st == cab_pkg::CAB_ST_EXEC);

  always_comb begin
    if (OP_FILE == cab_pkg::CAB_ADDR_PORT) begin
      fval = 8'(r_reg.pin_sync);
    end else if (OP_FILE == cab_pkg::CAB_ADDR_TIMER0) begin
      fval = r_reg.timer;
    end else begin
      fval = r_reg.mem[OP_FILE];
    end
  end

  assign bit_val = fval[OP_BIT];
  assign sum = {1'b0, r_reg.work} + {1'b0, fval};
  assign nib = {1'b0, r_reg.work[3:0]} + {1'b0, fval[3:0]};

  // ==========================================================================
  // Next state
  always_comb begin
    r_next = r_reg;
    res = fval;
    to_file = 1'b0;
    skip_take = 1'b0;
    r_next.pin_meta = PIN_IN;
    r_next.pin_sync = r_reg.pin_meta;
    r_next.presc = r_reg.presc + 8'h01;
    if (!r_reg.presc_timer || r_reg.presc == cab_pkg::CAB_PRESC_LAST) begin
      r_next.timer = r_reg.timer + 8'h01;
    end
    unique case (r_reg.st)
      cab_pkg::CAB_ST_EXEC: begin
        r_next.skip = 1'b0;
        if (exec) begin
          case (op)
            cab_pkg::CAB_OP_ADD_LITERAL_TO_WORKING: begin
              r_next.work = r_reg.work + OP_LIT;
              r_next.flags[cab_pkg::CAB_FLAG_C] = ({1'b0, r_reg.work} + {1'b0, OP_LIT}) > 9'h0FF;
              r_next.flags[cab_pkg::CAB_FLAG_DC] = ({1'b0, r_reg.work[3:0]} + {1'b0, OP_LIT[3:0]}) > 5'h0F;
              r_next.flags[cab_pkg::CAB_FLAG_Z] = (r_reg.work + OP_LIT) == 8'h00;
            end
            cab_pkg::CAB_OP_AND_LITERAL_WITH_WORKING: begin
              r_next.work = r_reg.work & OP_LIT;
              r_next.flags[cab_pkg::CAB_FLAG_Z] = (r_reg.work & OP_LIT) == 8'h00;
            end
            cab_pkg::CAB_OP_ADD_WORKING_TO_FILE: begin
              res = sum[7:0];
              to_file = OP_DEST;
              r_next.flags[cab_pkg::CAB_FLAG_C] = sum[8];
              r_next.flags[cab_pkg::CAB_FLAG_DC] = nib[4];
              r_next.flags[cab_pkg::CAB_FLAG_Z] = sum[7:0] == 8'h00;
            end
            cab_pkg::CAB_OP_AND_WORKING_WITH_FILE: begin
              res = r_reg.work & fval;
              to_file = OP_DEST;
              r_next.flags[cab_pkg::CAB_FLAG_Z] = (r_reg.work & fval) == 8'h00;
            end
            cab_pkg::CAB_OP_MOVE_FILE_REGISTER: begin
              to_file = OP_DEST;
              r_next.flags[cab_pkg::CAB_FLAG_Z] = fval == 8'h00;
            end
            cab_pkg::CAB_OP_CLEAR_FILE_BIT: begin
              res[OP_BIT] = 1'b0;
              to_file = 1'b1;
            end
            cab_pkg::CAB_OP_SET_FILE_BIT: begin
              res[OP_BIT] = 1'b1;
              to_file = 1'b1;
            end
            cab_pkg::CAB_OP_TEST_BIT_SKIP_WHEN_ONE: begin
              skip_take = bit_val;
            end
            cab_pkg::CAB_OP_TEST_BIT_SKIP_WHEN_ZERO: begin
              skip_take = !bit_val;
            end
            default: begin
            end
          endcase
          if (op == cab_pkg::CAB_OP_ADD_WORKING_TO_FILE || op == cab_pkg::CAB_OP_AND_WORKING_WITH_FILE ||
              op == cab_pkg::CAB_OP_MOVE_FILE_REGISTER) begin
            if (!OP_DEST) begin
              r_next.work = res;
            end
          end
          if (to_file) begin
            if (OP_FILE == cab_pkg::CAB_ADDR_PORT) begin
              r_next.port_latch = res[cab_pkg::CAB_PORT_W-1:0];
            end else if (OP_FILE == cab_pkg::CAB_ADDR_TIMER0) begin
              r_next.timer = res;
              if (r_reg.presc_timer) begin
                r_next.presc = 8'h00;
              end
            end else begin
              r_next.mem[OP_FILE] = res;
            end
          end
          if (skip_take) begin
            r_next.st = cab_pkg::CAB_ST_DISCARD;
            r_next.skip = 1'b1;
          end
        end
      end
      cab_pkg::CAB_ST_DISCARD: begin
        r_next.st = cab_pkg::CAB_ST_EXEC;
        r_next.skip = 1'b0;
      end
    endcase

    // Register bus write: address and data are taken together.
    r_next.awready = !r_reg.awready && !r_reg.bvalid && S_AXI_AWVALID && S_AXI_WVALID;
    if (r_reg.awready) begin
      r_next.bvalid = 1'b1;
      r_next.bresp = cab_pkg::CAB_RESP_OKAY;
      if (S_AXI_AWADDR == cab_pkg::CAB_OFS_CTRL) begin
        if (S_AXI_WSTRB[0]) begin
          r_next.presc_timer = S_AXI_WDATA[cab_pkg::CAB_CTRL_PRESC_TIMER];
        end
      end else if (S_AXI_AWADDR != cab_pkg::CAB_OFS_WORK && S_AXI_AWADDR != cab_pkg::CAB_OFS_FLAGS &&
                   S_AXI_AWADDR != cab_pkg::CAB_OFS_TIMER) begin
        r_next.bresp = cab_pkg::CAB_RESP_SLVERR;
      end
    end else if (r_reg.bvalid && S_AXI_BREADY) begin
      r_next.bvalid = 1'b0;
    end

    // Register bus read.
    r_next.arready = !r_reg.arready && !r_reg.rvalid && S_AXI_ARVALID;
    if (r_reg.arready) begin
      r_next.rvalid = 1'b1;
      r_next.rresp = cab_pkg::CAB_RESP_OKAY;
      unique case (S_AXI_ARADDR)
        cab_pkg::CAB_OFS_CTRL: r_next.rdata = 32'(r_reg.presc_timer);
        cab_pkg::CAB_OFS_WORK: r_next.rdata = 32'(r_reg.work);
        cab_pkg::CAB_OFS_FLAGS: r_next.rdata = 32'(r_reg.flags);
        cab_pkg::CAB_OFS_TIMER: r_next.rdata = 32'(r_reg.timer);
        default: begin
          r_next.rdata = 32'h00000000;
          r_next.rresp = cab_pkg::CAB_RESP_SLVERR;
        end
      endcase
    end else if (r_reg.rvalid && S_AXI_RREADY) begin
      r_next.rvalid = 1'b0;
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      r_reg <= '0;
      r_reg.presc_timer <= cab_pkg::CAB_CTRL_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  assign PORT_OUT = r_reg.port_latch;
  assign W_OUT = r_reg.work;
  assign FLAGS_OUT = r_reg.flags;
  assign SKIP_OUT = r_reg.skip;
  assign S_AXI_AWREADY = r_reg.awready;
  assign S_AXI_WREADY = r_reg.awready;
  assign S_AXI_BVALID = r_reg.bvalid;
  assign S_AXI_BRESP = r_reg.bresp;
  assign S_AXI_ARREADY = r_reg.arready;
  assign S_AXI_RVALID = r_reg.rvalid;
  assign S_AXI_RRESP = r_reg.rresp;
  assign S_AXI_RDATA = r_reg.rdata;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  sequence skip_start_s;
    exec && skip_take;
  endsequence
  sequence discard_then_resume_s;
    SKIP_OUT ##1 (!SKIP_OUT && r_reg.st == cab_pkg::CAB_ST_EXEC);
  endsequence

  AST_SKIP_TWO_CYCLES: assert property (skip_start_s |=> discard_then_resume_s)
    else $error("Skip did not give exactly one discarded cycle.");
  AST_SKIP_WHEN_ONE: assert property (exec && op == cab_pkg::CAB_OP_TEST_BIT_SKIP_WHEN_ONE |=>
    SKIP_OUT == $past(bit_val) && $stable(FLAGS_OUT))
    else $error("Skip on set bit wrong.");
  AST_SKIP_WHEN_ZERO: assert property (exec && op == cab_pkg::CAB_OP_TEST_BIT_SKIP_WHEN_ZERO |=>
    SKIP_OUT == !$past(bit_val) && $stable(W_OUT))
    else $error("Skip on clear bit wrong.");
  AST_PORT_USES_PINS: assert property (exec && op == cab_pkg::CAB_OP_MOVE_FILE_REGISTER && !OP_DEST &&
    OP_FILE == cab_pkg::CAB_ADDR_PORT |=> W_OUT == 8'($past(r_reg.pin_sync)))
    else $error("Port read did not use pin levels.");
  AST_PRESC_CLEAR: assert property (exec && to_file && OP_FILE == cab_pkg::CAB_ADDR_TIMER0 &&
    r_reg.presc_timer |=> r_reg.presc == 8'h00 ##1 r_reg.presc == 8'h01)
    else $error("Prescaler not cleared on timer write.");
  AST_ADD_LITERAL: assert property (exec && op == cab_pkg::CAB_OP_ADD_LITERAL_TO_WORKING |=>
    W_OUT == 8'($past(r_reg.work) + $past(OP_LIT)) &&
    FLAGS_OUT[cab_pkg::CAB_FLAG_Z] == (W_OUT == 8'h00))
    else $error("Literal add result wrong.");
  AST_AND_LITERAL: assert property (exec && op == cab_pkg::CAB_OP_AND_LITERAL_WITH_WORKING |=>
    W_OUT == ($past(r_reg.work) & $past(OP_LIT)) && FLAGS_OUT[1:0] == $past(r_reg.flags[1:0]))
    else $error("Literal AND result or flags wrong.");
  AST_BIT_CLEAR: assert property (exec && op == cab_pkg::CAB_OP_CLEAR_FILE_BIT && OP_FILE > 7'h05 |=>
    r_reg.mem[$past(OP_FILE)][$past(OP_BIT)] == 1'b0 && $stable(FLAGS_OUT))
    else $error("Bit clear failed.");
  AST_BIT_SET: assert property (exec && op == cab_pkg::CAB_OP_SET_FILE_BIT && OP_FILE > 7'h05 |=>
    r_reg.mem[$past(OP_FILE)][$past(OP_BIT)] == 1'b1 && $stable(FLAGS_OUT))
    else $error("Bit set failed.");
  AST_DEST_FILE_KEEPS_W: assert property (exec && OP_DEST && (op == cab_pkg::CAB_OP_ADD_WORKING_TO_FILE ||
    op == cab_pkg::CAB_OP_AND_WORKING_WITH_FILE) |=> $stable(W_OUT))
    else $error("Working register changed for file destination.");
  AST_ADD_FILE_CARRY: assert property (exec && op == cab_pkg::CAB_OP_ADD_WORKING_TO_FILE |=>
    FLAGS_OUT[cab_pkg::CAB_FLAG_C] == $past(sum[8]) && FLAGS_OUT[cab_pkg::CAB_FLAG_DC] == $past(nib[4]))
    else $error("Add carry flags wrong.");
  AST_AND_FILE_TO_W: assert property (exec && !OP_DEST && op == cab_pkg::CAB_OP_AND_WORKING_WITH_FILE |=>
    W_OUT == ($past(r_reg.work) & $past(fval)) && FLAGS_OUT[cab_pkg::CAB_FLAG_Z] == (W_OUT == 8'h00))
    else $error("File AND result wrong.");
  AST_ONE_CYCLE_RMW: assert property (exec && OP_DEST && op == cab_pkg::CAB_OP_ADD_WORKING_TO_FILE &&
    OP_FILE > 7'h05 |=> r_reg.mem[$past(OP_FILE)] == $past(sum[7:0]) && !SKIP_OUT)
    else $error("File update not done in one cycle.");
  AST_ZERO_FLAG: assert property (exec && op == cab_pkg::CAB_OP_MOVE_FILE_REGISTER |=>
    FLAGS_OUT[cab_pkg::CAB_FLAG_Z] == ($past(fval) == 8'h00))
    else $error("Zero flag wrong.");
endmodule // cab_alu
`default_nettype wire

//--- cab_alu_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module cab_alu_tb_top;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [5:0] pin_in = '0;
  logic [5:0] port_out;
  logic [7:0] w_out, aw_addr = '0, ar_addr = '0;
  logic [2:0] flags_out;
  logic skip_out, op_valid, op_dest;
  logic [3:0] op_code;
  logic [6:0] op_file;
  logic [2:0] op_bit;
  logic [7:0] op_lit;
  logic aw_valid = 0, w_valid = 0, b_ready = 0, ar_valid = 0, r_ready = 0, aw_ready, w_ready, b_valid, ar_ready, r_valid;
  logic [31:0] w_data = '0, r_data;
  logic [1:0] b_resp, r_resp;
  logic [7:0] w_m = '0;
  logic [2:0] fl_m = '0;
  logic [7:0] mem_m [0:127] = '{default: 8'h00};
  logic [31:0] seed = 32'h366BEC5F;
  int n_errors = 0, checks_done = 0, cyc = 0;
  always #5 clk = ~clk;
  cab_seq_model u_seq (.clk(clk), .op_valid(op_valid), .op_code(op_code), .op_file(op_file), .op_bit(op_bit),
    .op_lit(op_lit), .op_dest(op_dest));
  cab_alu DUT (.CLK(clk), .ARST_N(arst_n), .OP_VALID(op_valid), .OP_CODE(op_code), .OP_FILE(op_file),
    .OP_BIT(op_bit), .OP_LIT(op_lit), .OP_DEST(op_dest), .PIN_IN(pin_in), .PORT_OUT(port_out), .W_OUT(w_out),
    .FLAGS_OUT(flags_out), .SKIP_OUT(skip_out), .S_AXI_AWADDR(aw_addr), .S_AXI_AWVALID(aw_valid),
    .S_AXI_AWREADY(aw_ready), .S_AXI_WDATA(w_data), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(w_valid),
    .S_AXI_WREADY(w_ready), .S_AXI_BRESP(b_resp), .S_AXI_BVALID(b_valid), .S_AXI_BREADY(b_ready),
    .S_AXI_ARADDR(ar_addr), .S_AXI_ARVALID(ar_valid), .S_AXI_ARREADY(ar_ready), .S_AXI_RDATA(r_data),
    .S_AXI_RRESP(r_resp), .S_AXI_RVALID(r_valid), .S_AXI_RREADY(r_ready));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk_core(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_bus(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] bus %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    {aw_addr, w_data, aw_valid, w_valid, b_ready} <= {a, d, 3'b111};
    do @(posedge clk); while (aw_ready !== 1'b1);
    {aw_addr, w_data, aw_valid, w_valid} <= {~a, ~d, 2'b00};
    while (b_valid !== 1'b1) @(posedge clk);
    r = b_resp;
    b_ready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    {ar_addr, ar_valid, r_ready} <= {a, 2'b11};
    do @(posedge clk); while (ar_ready !== 1'b1);
    {ar_addr, ar_valid} <= {~a, 1'b0};
    while (r_valid !== 1'b1) @(posedge clk);
    {d, r} = {r_data, r_resp};
    r_ready <= 1'b0;
  endtask
  // Reference model of one instruction, codes as in cab_pkg::cab_op_t.
  task automatic model(input logic [3:0] c, input logic [6:0] f, input logic [2:0] b, input logic [7:0] k,
                       input logic d);
    logic [7:0] a, res;
    logic [8:0] s;
    a = (c == 4'h1 || c == 4'h2) ? k : mem_m[f];
    s = w_m + a;
    res = a;
    case (c)
      4'h1, 4'h3: begin
        res = s[7:0];
        fl_m = {s[7:0] == 0, ({1'b0, w_m[3:0]} + a[3:0]) > 15, s[8]};
      end
      4'h2, 4'h4: begin
        res = w_m & a;
        fl_m[2] = res == 0;
      end
      4'h9: fl_m[2] = a == 0;
      4'h5: res = a & ~(8'h01 << b);
      4'h6: res = a | (8'h01 << b);
      default: ;
    endcase
    if (c == 4'h1 || c == 4'h2 || (c inside {4'h3, 4'h4, 4'h9} && !d)) w_m = res;
    else if (c inside {4'h3, 4'h4, 4'h9, 4'h5, 4'h6}) mem_m[f] = res;
  endtask
  task automatic run(input logic [3:0] c, input logic [6:0] f, input logic [2:0] b, input logic [7:0] k,
                     input logic d);
    model(c, f, b, k, d);
    u_seq.issue(c, f, b, k, d);
    u_seq.idle();
    #1;
    chk_core("w", w_m, w_out);
    chk_core("flags", fl_m, flags_out);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      summarize();
    end
  end
  initial begin
    logic [31:0] x, d;
    logic [1:0] r;
    static logic [3:0] ops [7] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9};
    logic [3:0] tst;
    logic sk;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk_core("w reset", 0, {w_out, flags_out, skip_out, port_out});
    axi_rd(cab_pkg::CAB_OFS_CTRL, d, r);
    chk_bus("ctrl reset", 1, d);
    axi_rd(8'h40, d, r);
    chk_bus("unmapped rresp", cab_pkg::CAB_RESP_SLVERR, r);
    axi_wr(8'h44, 1, r);
    chk_bus("unmapped bresp", cab_pkg::CAB_RESP_SLVERR, r);
    axi_wr(cab_pkg::CAB_OFS_CTRL, 0, r);
    axi_rd(cab_pkg::CAB_OFS_CTRL, d, r);
    chk_bus("ctrl rw", 0, d);
    axi_wr(cab_pkg::CAB_OFS_CTRL, 1, r);
    for (int i = 0; i < 80; i++) begin
      x = rnd();
      run(ops[x[2:0] % 7], 7'h20 + x[12:8], x[15:13], x[23:16], x[24]);
    end
    axi_rd(cab_pkg::CAB_OFS_WORK, d, r);
    chk_bus("work", w_m, d);
    for (int i = 0; i < 4; i++) begin
      tst = i[0] ? cab_pkg::CAB_OP_TEST_BIT_SKIP_WHEN_ONE : cab_pkg::CAB_OP_TEST_BIT_SKIP_WHEN_ZERO;
      sk = i[0] == i[1];
      run(i[1] ? 4'h6 : 4'h5, 7'h30, 3'd7, 0, 0);
      u_seq.issue(tst, 7'h30, 3'd7, 0, 0);
      u_seq.issue(cab_pkg::CAB_OP_ADD_LITERAL_TO_WORKING, 0, 0, 8'h9C, 0);
      #1;
      chk_core("skip", sk, skip_out);
      u_seq.idle();
      #1;
      chk_core("skip one cycle", 0, skip_out);
      if (!sk) model(4'h1, 0, 0, 8'h9C, 0);
      chk_core("w after test", {w_m, fl_m}, {w_out, flags_out});
    end
    for (int j = 0; j < 3; j++) begin
      x = rnd();
      @(posedge clk);
      pin_in <= x[5:0] & ~(6'h01 << j);
      repeat (3) @(posedge clk);
      mem_m[5] = {2'b00, pin_in};
      run(cab_pkg::CAB_OP_SET_FILE_BIT, cab_pkg::CAB_ADDR_PORT, j, 0, 0);
      chk_core("port", pin_in | (6'h01 << j), port_out);
      mem_m[5] = {2'b00, pin_in};
      run(cab_pkg::CAB_OP_MOVE_FILE_REGISTER, cab_pkg::CAB_ADDR_PORT, 3'h0, 8'h00, 1'b0);
    end
    run(4'h2, 0, 0, 8'h00, 0);
    mem_m[1] = 8'h00;
    run(cab_pkg::CAB_OP_AND_WORKING_WITH_FILE, cab_pkg::CAB_ADDR_TIMER0, 0, 0, 1);
    repeat (100) @(posedge clk);
    axi_rd(cab_pkg::CAB_OFS_TIMER, d, r);
    chk_bus("timer early", 0, d);
    repeat (300) @(posedge clk);
    axi_rd(cab_pkg::CAB_OFS_TIMER, d, r);
    chk_bus("timer late", 1, d);
    summarize();
  end
endmodule // cab_alu_tb_top
`default_nettype wire

//--- cab_pkg.sv
// Notes on behaviour
// - A port read-modify-write takes the synchronised pin levels, not the output latch.
// - Writing a result into the timer0 count clears the prescaler when it belongs there.
// - A skip costs two cycles, the second a no-operation.
// - add_literal_to_working adds an 8-bit literal to W; C, digit carry, Z change.
// - clear_file_bit zeroes bit b of file register f; flags untouched.
// - add_working_to_file adds W and f into W or f; C, digit carry, Z change.
// - set_file_bit sets bit b of file register f; flags untouched.
// - and_literal_with_working ANDs W with a literal into W; only Z changes.
// - test_bit_skip_when_one discards the next instruction when the bit is one.
// - and_working_with_file ANDs W with f into W or f; only Z changes.
// - test_bit_skip_when_zero discards the next instruction when the bit is zero.
// - Destination select 0 routes the result to W, 1 to the file register.
`default_nettype none
package cab_pkg;
  // ==========================================================================
  // File map and flags
  localparam logic [6:0] CAB_ADDR_TIMER0 = 7'h01;
  localparam logic [6:0] CAB_ADDR_PORT = 7'h05;
  localparam int CAB_PORT_W = 6;
  localparam int CAB_FLAG_C = 0;
  localparam int CAB_FLAG_DC = 1;
  localparam int CAB_FLAG_Z = 2;
  localparam logic [7:0] CAB_PRESC_LAST = 8'hFF;
  // ==========================================================================
  // Register bus map
  localparam logic [7:0] CAB_OFS_CTRL = 8'h00;
  localparam logic [7:0] CAB_OFS_WORK = 8'h04;
  localparam logic [7:0] CAB_OFS_FLAGS = 8'h08;
  localparam logic [7:0] CAB_OFS_TIMER = 8'h0C;
  localparam int CAB_CTRL_PRESC_TIMER = 0;
  localparam logic CAB_CTRL_RESET = 1'h1;
  localparam logic [1:0] CAB_RESP_OKAY = 2'h0;
  localparam logic [1:0] CAB_RESP_SLVERR = 2'h2;
  // ==========================================================================
  // Operations and states
  typedef enum logic [3:0] {
    CAB_OP_NOP,
    CAB_OP_ADD_LITERAL_TO_WORKING,
    CAB_OP_AND_LITERAL_WITH_WORKING,
    CAB_OP_ADD_WORKING_TO_FILE,
    CAB_OP_AND_WORKING_WITH_FILE,
    CAB_OP_CLEAR_FILE_BIT,
    CAB_OP_SET_FILE_BIT,
    CAB_OP_TEST_BIT_SKIP_WHEN_ONE,
    CAB_OP_TEST_BIT_SKIP_WHEN_ZERO,
    CAB_OP_MOVE_FILE_REGISTER
  } cab_op_t;
  typedef enum logic [0:0] {
    CAB_ST_EXEC,
    CAB_ST_DISCARD
  } cab_state_t;
endpackage
`default_nettype wire

//--- cab_seq_model.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Sequencer model: presents one decoded instruction per cycle.
module cab_seq_model (
  // Clock
  input wire logic clk,
  // Decoded instruction
  output logic op_valid,
  output logic [3:0] op_code,
  output logic [6:0] op_file,
  output logic [2:0] op_bit,
  output logic [7:0] op_lit,
  output logic op_dest
);
  initial begin
    {op_valid, op_code, op_file, op_bit, op_lit, op_dest} = '0;
  end
  // The next instruction is presented even after a skip; the core must drop it.
  task automatic issue(input logic [3:0] c, input logic [6:0] f, input logic [2:0] b, input logic [7:0] k,
                       input logic d);
    @(posedge clk);
    op_valid <= 1'b1;
    {op_code, op_file, op_bit, op_lit, op_dest} <= {c, f, b, k, d};
  endtask
  // Idle fields carry inverted junk, never the last instruction.
  task automatic idle();
    @(posedge clk);
    op_valid <= 1'b0;
    {op_code, op_file, op_bit, op_lit, op_dest} <= ~{op_code, op_file, op_bit, op_lit, op_dest};
  endtask
endmodule // cab_seq_model
`default_nettype wire
